// file: testbench/dtc_cpu_model.sv
`timescale 1ns/1ns
module dtc_cpu_model
   import dtc_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic rd,
   input wire logic [15:0] addr,
   output dtc_bus_t bus
);
   initial bus = '0;
   // one access per go; idle cycles show inverted lines so a stale match cannot pass
   always @(posedge clk) begin
      bus.valid <= go;
      bus.read <= go ? rd : ~bus.read;
      bus.addr <= go ? addr : ~bus.addr;
   end
endmodule

// file: testbench/dtc_monitor.sv
`timescale 1ns/1ns
module dtc_monitor
   import dtc_pkg::*;
#(
   parameter int trace_depth = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic secure_in,
   input wire dtc_bus_t bus,
   input wire logic [15:0] cmp_a_value,
   input wire logic [15:0] cmp_b_value,
   input wire dtc_brk_t brk,
   input wire logic capture_store,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // setup and access phases of one transfer
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   chk_ready_next: assert property (s_setup |=> s_access)
      else $error("transfer not answered at once");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_no_error: assert property (pready |-> !pslverr)
      else $error("slave error raised");
   chk_upper_zero: assert property (pready && !pwrite && paddr != dtc_off_trace |->
      prdata[31:8] == 24'h0) else $error("upper read bits set");
   chk_break_type: assert property (!(brk.force_req && brk.tag_req))
      else $error("both break kinds at once");
   chk_break_cause: assert property (brk != 2'b00 |-> $past(bus.valid, 2) ||
      $past(bus.valid, 3) || $past(bus.valid, 4)) else $error("break without access");
   chk_break_once: assert property (brk != 2'b00 |=> brk == 2'b00 [*3])
      else $error("run went on after break");
   chk_store_cause: assert property (capture_store |-> $past(bus.valid, 2) ||
      $past(bus.valid, 3)) else $error("store without access");
   chk_irq_fall: assert property ($fell(irq) |-> $past(psel && penable, 1) ||
      $past(psel && penable, 2)) else $error("irq fell without access");
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
   import dtc_pkg::*;
   localparam int depth = 4;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, secure_in = 0;
   logic go = 0, rd = 0, tag_seen = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv;
   logic pready, pslverr, capture_store, irq;
   logic [15:0] cmp_a_value = 16'h1234, cmp_b_value = 16'h5678, addr = '0;
   dtc_bus_t bus;
   dtc_brk_t brk;
   int errors = 0, check_count = 0, nbrk = 0, nst = 0;
   dtc_top #(.trace_depth(depth)) uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .secure_in, .bus, .cmp_a_value, .cmp_b_value,
      .brk, .capture_store, .irq);
   dtc_cpu_model cpu (.clk, .go, .rd, .addr, .bus);
   always #20 clk = ~clk;
   // tally break pulses between accesses
   always @(posedge clk) begin
      if (brk.force_req || brk.tag_req) nbrk <= nbrk + 1;
      if (brk.tag_req) tag_seen <= 1'b1;
      if (capture_store) nst <= nst + 1;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t %s seen %h want %h", $time, m, seen, exp);
      end
   endtask
   // one transfer, held until ready is sampled, then an idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rv = prdata;
      if (n == 20) begin
         errors++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      check(rv, e, m);
   endtask
   task automatic access(input logic [15:0] a, input logic r);
      nbrk = 0;
      nst = 0;
      tag_seen = 1'b0;
      addr <= a;
      rd <= r;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   // enable and arm; direction bits land on comparator A or B
   function automatic logic [7:0] qual_ctl(input logic [4:0] i, input logic t);
      return {2'b11, t, i[0], i[4] ? {2'b00, i[2], i[3]} : {i[2], i[3], 2'b00}};
   endfunction
   initial begin
      logic [4:0] x;
      logic [7:0] ctl;
      logic t, m, h;
      int tot;
      void'($urandom(70939));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdchk(dtc_off_control, 32'h0, "ctl reset");
      rdchk(12'hFF0, 32'h0, "unmapped");
      repeat (6) begin
         ctl = 8'($urandom()) & 8'hBF;
         apb(1'b1, dtc_off_control, {24'h0, ctl});
         rdchk(dtc_off_control, {24'h0, ctl}, "ctl rw");
      end
      secure_in <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b1, dtc_off_control, 32'hBF);
      rdchk(dtc_off_control, 32'h3F, "secured enable");
      secure_in <= 1'b0;
      repeat (3) @(posedge clk);
      $display("test control done");
      for (int i = 0; i < 32; i++) begin
         x = i[4:0];
         t = 1'($urandom_range(1));
         m = 1'($urandom_range(1));
         h = !x[3] || (x[2] == x[1]);
         ctl = qual_ctl(x, t);
         apb(1'b1, dtc_off_mask, {31'h0, m});
         apb(1'b1, dtc_off_cfg, x[4] ? 32'h2 : 32'h0);
         apb(1'b1, dtc_off_control, {24'h0, ctl});
         access(x[4] ? cmp_b_value : cmp_a_value, x[1]);
         check(nbrk, h && x[0], "break count");
         check(tag_seen, h && x[0] && t, "break type");
         check(nst, 1, "store per access");
         check(irq, h && m, "irq level");
         rdchk(dtc_off_control, {24'h0, ctl & ~{1'b0, h, 6'h0}}, "arm cleared");
         rdchk(dtc_off_status, h ? 32'h3 : 32'h0, "status");
         check(irq, 1'b0, "irq after read");
      end
      $display("test qualify done");
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, dtc_off_cfg, 32'h0);
         apb(1'b1, dtc_off_control, 32'hD0);
         apb(1'b1, dtc_off_control, j ? 32'h50 : 32'h90);
         access(cmp_a_value, 1'b0);
         check(nbrk, 0, "stopped run");
      end
      for (int s = 0; s < 2; s++) begin
         tot = 0;
         apb(1'b1, dtc_off_cfg, s ? 32'h9 : 32'h1);
         apb(1'b1, dtc_off_control, 32'hD0);
         for (int k = 0; k < 10; k++) begin
            access(cmp_a_value, 1'($urandom_range(1)));
            apb(1'b0, dtc_off_trace, 32'h0);
            if (nbrk > 0) check(rv[7:0], depth, "full at break");
            tot += nbrk;
         end
         check(tot, 1, "one break");
      end
      $display("test begin trace done");
      finish_test();
   end
endmodule
bind dtc_top dtc_monitor #(.trace_depth(trace_depth)) mon (.clk, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .secure_in, .bus, .cmp_a_value,
   .cmp_b_value, .brk, .capture_store, .irq);

// file: verilog/dtc_cmp.sv
`timescale 1ns/1ns
module dtc_cmp (
   input wire logic clk,
   input wire logic sys_rst,
   input wire dtc_pkg::dtc_bus_t bus,
   input wire logic [15:0] value,
   input wire logic dir_qualify,
   input wire logic dir_value,
   output logic hit
);
   import dtc_pkg::*;
   typedef struct packed {
      logic hit;
   } dtc_cmp_state_t;
   dtc_cmp_state_t st;
   dtc_cmp_state_t next_st;
   // direction only counts when qualified; value one means read, zero write
   always_comb begin
      next_st = st;
      next_st.hit = bus.valid && (bus.addr == value) &&
         (!dir_qualify || (bus.read == dir_value));
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign hit = st.hit;
endmodule

// file: verilog/dtc_pkg.sv
// Function
// - The control register can be read and written at any time, whatever the armed state.
// - Bit 7 enables the debug module and cannot be set while the device is secured.
// - Writing bit 6 to one with bit 7 set in the same write arms the module and sets the armed flag; armed means compare and store.
// - The arm bit clears by itself when a debug run completes.
// - Writing zero to the arm bit or the enable bit stops a run at once.
// - Bit 5 picks the break type: zero gives force breaks, one gives tag breaks.
// - With breaks disabled the break type bit has no effect at all.
// - Bit 4 enables breaks; with it clear triggers may still store trace data but never break.
// - An end trace with breaks enabled breaks when the trigger condition is met.
// - A begin trace with breaks enabled breaks only when the trace store is full.
// - The trigger point selection has no influence on break timing.
// - Bit 2 decides whether bus direction takes part in the comparator A match.
// - With direction qualify on for A, bit 3 zero matches writes only and one reads only.
// - Bit 0 decides whether bus direction takes part in the comparator B match.
// - With direction qualify on for B, bit 1 zero matches writes only and one reads only.
package dtc_pkg;
   localparam logic [11:0] dtc_off_control = 12'h000;
   localparam logic [11:0] dtc_off_status = 12'h004;
   localparam logic [11:0] dtc_off_mask = 12'h008;
   localparam logic [11:0] dtc_off_trace = 12'h00C;
   localparam logic [11:0] dtc_off_cfg = 12'h010;
   localparam logic [7:0] dtc_control_reset = 8'h00;
   localparam int dtc_bit_enable = 7;
   localparam int dtc_bit_arm = 6;
   localparam int dtc_bit_tag = 5;
   localparam int dtc_bit_break_request_enable = 4;
   localparam int dtc_bit_rwa = 3;
   localparam int dtc_bit_cmp_a_direction_qualify = 2;
   localparam int dtc_bit_rwb = 1;
   localparam int dtc_bit_cmp_b_direction_qualify = 0;
   // trigger modes of the comparator pair
   typedef enum logic [1:0] {
      dtc_trig_a_only = 2'b00,
      dtc_trig_a_or_b = 2'b01,
      dtc_trig_a_and_b = 2'b10
   } dtc_trig_t;
   // cpu bus observation
   typedef struct packed {
      logic valid;
      logic read;
      logic [15:0] addr;
   } dtc_bus_t;
   // break request out to the cpu
   typedef struct packed {
      logic force_req;
      logic tag_req;
   } dtc_brk_t;
endpackage

// file: verilog/dtc_top.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module dtc_top #(
   parameter int trace_depth = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic secure_in,
   input wire dtc_pkg::dtc_bus_t bus,
   input wire logic [15:0] cmp_a_value,
   input wire logic [15:0] cmp_b_value,
   output dtc_pkg::dtc_brk_t brk,
   output logic capture_store,
   output logic irq
);
   import dtc_pkg::*;
   typedef struct packed {
      logic sec_s1;
      logic sec_s2;
      logic [7:0] ctrl;
      logic capture_active_flag;
      logic [1:0] status;
      logic [1:0] mask;
      logic begin_trace;
      dtc_trig_t trig;
      logic trigger_point_select;
      logic triggered;
      logic bus_seen;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      dtc_brk_t brk;
      logic store;
      logic irq;
   } dtc_state_t;
   dtc_state_t st;
   dtc_state_t next_st;
   logic hit_a;
   logic hit_b;
   logic trace_full;
   logic [7:0] trace_count;
   logic trace_clear;
   logic trig_now;
   logic run_done;
   logic setup;
   logic wr;
   logic rd;
   logic [7:0] wv;

   dtc_cmp u_cmp_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(bus),
      .value(cmp_a_value),
      .dir_qualify(st.ctrl[dtc_bit_cmp_a_direction_qualify]),
      .dir_value(st.ctrl[dtc_bit_rwa]),
      .hit(hit_a)
   );
   dtc_cmp u_cmp_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(bus),
      .value(cmp_b_value),
      .dir_qualify(st.ctrl[dtc_bit_cmp_b_direction_qualify]),
      .dir_value(st.ctrl[dtc_bit_rwb]),
      .hit(hit_b)
   );
   dtc_trace #(
      .depth(trace_depth)
   ) u_trace (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(trace_clear),
      .store(st.store),
      .full(trace_full),
      .count(trace_count)
   );

   // apb decode: zero wait state, each access answered in its access phase
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign wv = pwdata[7:0];
   // a fresh arm empties the trace store
   assign trace_clear = wr && paddr == dtc_off_control && wv[dtc_bit_arm];

   // trigger condition from the comparator pair
   always_comb begin
      case (st.trig)
         dtc_trig_a_only: trig_now = hit_a;
         dtc_trig_a_or_b: trig_now = hit_a || hit_b;
         dtc_trig_a_and_b: trig_now = hit_a && hit_b;
         default: trig_now = hit_a;
      endcase
   end

   // end trace finishes on the trigger, begin trace once the store fills
   assign run_done = st.ctrl[dtc_bit_arm] && st.ctrl[dtc_bit_enable] &&
      (st.begin_trace ? (st.triggered && trace_full) : trig_now);

   always_comb begin
      next_st = st;
      next_st.sec_s1 = secure_in;
      next_st.sec_s2 = st.sec_s1;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.brk = '0;
      next_st.store = 1'b0;
      // valid delayed one cycle so it lines up with the registered comparator hits
      next_st.bus_seen = bus.valid;
      // armed and enabled: watch and store trace
      if (st.ctrl[dtc_bit_arm] && st.ctrl[dtc_bit_enable]) begin
         if (trig_now) begin
            next_st.triggered = 1'b1;
         end
         // begin trace stores after the trigger, end trace stores up to it
         // only real accesses are stored, so idle cycles never fill the store
         next_st.store = st.bus_seen && (st.begin_trace ? (st.triggered || trig_now) : 1'b1);
      end
      // break on completion; trigger point select plays no part here
      if (run_done && st.ctrl[dtc_bit_break_request_enable]) begin
         next_st.brk.tag_req = st.ctrl[dtc_bit_tag];
         next_st.brk.force_req = !st.ctrl[dtc_bit_tag];
      end
      if (run_done) begin
         next_st.ctrl[dtc_bit_arm] = 1'b0;
         next_st.capture_active_flag = 1'b0;
         next_st.triggered = 1'b0;
      end
      // apb access, no gating by armed state
      if (setup) begin
         next_st.pready = 1'b1;
      end
      if (wr) begin
         case (paddr)
            dtc_off_control: begin
               next_st.ctrl = wv;
               // secured parts keep the module off
               if (st.sec_s2) begin
                  next_st.ctrl[dtc_bit_enable] = 1'b0;
               end
               if (wv[dtc_bit_arm]) begin
                  next_st.capture_active_flag = 1'b1;
                  next_st.triggered = 1'b0;
               end
               // zero to arm or enable ends the run now
               if (!wv[dtc_bit_arm] || !next_st.ctrl[dtc_bit_enable]) begin
                  next_st.ctrl[dtc_bit_arm] = 1'b0;
                  next_st.capture_active_flag = 1'b0;
                  next_st.triggered = 1'b0;
               end
            end
            dtc_off_mask: next_st.mask = wv[1:0];
            dtc_off_cfg: begin
               next_st.begin_trace = wv[0];
               next_st.trig = dtc_trig_t'(wv[2:1]);
               next_st.trigger_point_select = wv[3];
            end
            dtc_off_status: ;
            default: next_st.pslverr = 1'b0;
         endcase
      end
      // read of status clears it; a new event in that cycle wins
      if (rd && paddr == dtc_off_status) begin
         next_st.status = 2'b00;
      end
      if (run_done) begin
         next_st.status[0] = 1'b1;
      end
      if (st.ctrl[dtc_bit_arm] && st.ctrl[dtc_bit_enable] && trig_now) begin
         next_st.status[1] = 1'b1;
      end
      // read data latched in setup so it is stable through the access phase
      if (setup && !pwrite) begin
         case (paddr)
            dtc_off_control: next_st.prdata = {24'h000000, st.ctrl};
            dtc_off_status: next_st.prdata = {30'h00000000, st.status};
            dtc_off_mask: next_st.prdata = {30'h00000000, st.mask};
            dtc_off_trace: next_st.prdata = {23'h000000, st.capture_active_flag, trace_count};
            dtc_off_cfg: next_st.prdata = {28'h0000000, st.trigger_point_select,
               st.trig, st.begin_trace};
            default: next_st.prdata = 32'h00000000;
         endcase
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   // reset clears the control register and everything else
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign brk = st.brk;
   assign capture_store = st.store;
   assign irq = st.irq;
endmodule

// file: verilog/dtc_trace.sv
`timescale 1ns/1ns
module dtc_trace #(
   parameter int depth = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic store,
   output logic full,
   output logic [7:0] count
);
   import dtc_pkg::*;
   typedef struct packed {
      logic [7:0] count;
   } dtc_trace_state_t;
   dtc_trace_state_t st;
   dtc_trace_state_t next_st;
   localparam logic [7:0] depth_w = 8'(depth);
   // only the fill level is kept; stored words live outside this block
   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.count = 8'h00;
      end else if (store && st.count != depth_w) begin
         next_st.count = st.count + 8'h01;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign full = (st.count == depth_w);
   assign count = st.count;
endmodule
